/* File: design/aux_pll_pkg.sv */
// constants, types and helpers shared by the aux clock / synth override block
package aux_pll_pkg;

   // ****************************************************************
   // register map of the serial register port
   // ****************************************************************
   localparam int ADDR_BITS = 15;
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h10;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h18;
   localparam logic [14:0] ADDR_AUX_CTRL = 15'h0057;
   localparam logic [14:0] ADDR_SYNTH_OVR = 15'h0058;
   localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
   localparam logic [7:0] SYNTH_OVR_RESET = 8'h00;

   // ****************************************************************
   // field encodings
   // ****************************************************************
   localparam logic [2:0] SEL_UI16 = 3'h0;
   localparam logic [2:0] SEL_UI32 = 3'h1;
   localparam logic [2:0] SEL_UI64 = 3'h2;
   localparam logic [2:0] SEL_TSTAMP = 3'h3;
   localparam logic [1:0] REFDIV_OFF = 2'h0;
   localparam logic [1:0] REFDIV_DIV1 = 2'h1;
   localparam logic [1:0] REFDIV_DIV2 = 2'h2;
   localparam logic [1:0] REFDIV_DIV4 = 2'h3;
   // half periods of the aux clock in unit-interval ticks
   localparam logic [5:0] HALF_UI16 = 6'h08;
   localparam logic [5:0] HALF_UI32 = 6'h10;
   localparam logic [5:0] HALF_UI64 = 6'h20;

   // ****************************************************************
   // bit positions in the synchronised pin vector
   // ****************************************************************
   localparam int PIN_W = 8;
   localparam int PIN_SDI = 0;
   localparam int PIN_CSB = 1;
   localparam int PIN_SCLK = 2;
   localparam int PIN_SYNTH_EN = 3;
   localparam int PIN_SE_REF = 4;
   localparam int PIN_CFG0 = 5;
   localparam int PIN_CFG1 = 6;
   localparam int PIN_TSTAMP = 7;
   // chip select idles high, everything else low
   localparam logic [7:0] PIN_RESET = 8'h02;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef struct packed {
      logic aux_out_enable;
      logic [3:0] reserved;
      logic [2:0] aux_out_select;
   } aux_ctrl_s;

   typedef struct packed {
      logic synth_override_enable;
      logic reserved;
      logic [1:0] refdiv_out_b_select;
      logic [1:0] refdiv_out_a_select;
      logic se_ref_select_value;
      logic synth_enable_value;
   } synth_ovr_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_HOLD = 3'b100
   } spi_state_e;

   // half period of the lane-derived aux clock for a select code
   function automatic logic [5:0] aux_half(input logic [2:0] sel);
      case (sel)
         SEL_UI16: aux_half = HALF_UI16;
         SEL_UI32: aux_half = HALF_UI32;
         default: aux_half = HALF_UI64;
      endcase
   endfunction

   // lane-derived aux source is used for codes 0 to 2
   function automatic logic aux_from_lane(input logic [2:0] sel);
      aux_from_lane = (sel <= SEL_UI64);
   endfunction

endpackage

/* File: design/pin_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   // a bit moves only once the second and third stage agree
   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         out_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign level_out = out_q;

endmodule

`default_nettype wire

/* File: design/aux_pll_ctrl.sv */
// aux clock output and clock-synth pin override with its serial register port
`timescale 1ns/1ps
`default_nettype none

module aux_pll_ctrl
   import aux_pll_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial register port
   input wire logic spi_sclk,
   input wire logic spi_csb,
   input wire logic spi_sdi,
   output logic spi_sdo_out,
   output logic spi_sdo_oe,
   // serializer side
   input wire logic ui_tick,
   input wire logic serializer_reinit,
   // board pins
   input wire logic timestamp_input_pair,
   input wire logic synth_enable_pin,
   input wire logic se_ref_select_pin,
   input wire logic clock_cfg_pin0,
   input wire logic clock_cfg_pin1,
   // aux output
   output logic aux_out_pair,
   output logic aux_out_enable,
   // synthesizer controls
   output logic synth_enable,
   output logic se_ref_select,
   output logic [1:0] refdiv_out_a,
   output logic [1:0] refdiv_out_b
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [PIN_W-1:0] pins_raw, pins_s;

   assign pins_raw = {timestamp_input_pair, clock_cfg_pin1, clock_cfg_pin0,
                      se_ref_select_pin, synth_enable_pin, spi_sclk, spi_csb, spi_sdi};

   pin_sync #(
      .W(PIN_W),
      .RESET_VAL(PIN_RESET)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .pin_in(pins_raw),
      .level_out(pins_s)
   );

   // ****************************************************************
   // serial register port
   // ****************************************************************
   // frame: read flag, 15 address bits, 8 data bits, msb first, mode 0
   spi_state_e state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [23:0] shreg_q, shreg_d;
   logic [7:0] tx_q, tx_d;
   logic sclk_p_q, sdo_q, sdo_d, oe_q, oe_d, rd_q, rd_d;
   aux_ctrl_s aux_q, aux_d;
   synth_ovr_s ovr_q, ovr_d;
   logic rise, fall, is_read;
   logic [14:0] addr;

   assign rise = pins_s[PIN_SCLK] && !sclk_p_q;
   assign fall = !pins_s[PIN_SCLK] && sclk_p_q;
   // the read flag climbs the shift register bit by bit, so it is latched at bit 16
   assign is_read = rd_q;
   assign addr = shreg_q[14:0];

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shreg_d = shreg_q;
      tx_d = tx_q;
      sdo_d = sdo_q;
      oe_d = oe_q;
      rd_d = rd_q;
      aux_d = aux_q;
      ovr_d = ovr_q;
      if (pins_s[PIN_CSB]) begin
         state_d = ST_IDLE;
         cnt_d = '0;
         oe_d = 1'b0;
         rd_d = 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_d = ST_SHIFT;
               cnt_d = '0;
            end
            ST_SHIFT: begin
               if (rise) begin
                  shreg_d = {shreg_q[22:0], pins_s[PIN_SDI]};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q + 5'h01 == CNT_ADDR_DONE) begin
                     rd_d = shreg_q[14];
                     // read data comes back from the addressed register
                     case ({shreg_q[13:0], pins_s[PIN_SDI]})
                        ADDR_AUX_CTRL: tx_d = aux_q;
                        ADDR_SYNTH_OVR: tx_d = ovr_q;
                        default: tx_d = 8'h00;
                     endcase
                  end
                  if (cnt_q + 5'h01 == CNT_FRAME_DONE) begin
                     state_d = ST_HOLD;
                     // reserved bits are stored as written, host keeps them zero
                     if (!shreg_q[22]) begin
                        // select should only move while disabled
                        if (shreg_q[21:7] == ADDR_AUX_CTRL) begin
                           aux_d = {shreg_q[6:0], pins_s[PIN_SDI]};
                        end else if (shreg_q[21:7] == ADDR_SYNTH_OVR) begin
                           ovr_d = {shreg_q[6:0], pins_s[PIN_SDI]};
                        end
                     end
                  end
               end
               if (fall && cnt_q >= CNT_ADDR_DONE && is_read) begin
                  sdo_d = tx_q[7];
                  tx_d = {tx_q[6:0], 1'b0};
                  oe_d = 1'b1;
               end
            end
            ST_HOLD: begin
               // extra clocks after a full frame are ignored until deselect
               if (fall) begin
                  oe_d = 1'b0;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         shreg_q <= '0;
         tx_q <= '0;
         sclk_p_q <= 1'b0;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
         rd_q <= 1'b0;
         aux_q <= AUX_CTRL_RESET;
         ovr_q <= SYNTH_OVR_RESET;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shreg_q <= shreg_d;
         tx_q <= tx_d;
         sclk_p_q <= pins_s[PIN_SCLK];
         sdo_q <= sdo_d;
         oe_q <= oe_d;
         rd_q <= rd_d;
         aux_q <= aux_d;
         ovr_q <= ovr_d;
      end
   end

   assign spi_sdo_out = sdo_q;
   assign spi_sdo_oe = oe_q;

   // ****************************************************************
   // aux output
   // ****************************************************************
   logic [5:0] div_q, div_d;
   logic aux_out_q, aux_out_d, aux_en_q;

   always_comb begin
      div_d = div_q;
      aux_out_d = aux_out_q;
      if (!aux_q.aux_out_enable) begin
         // buffer and divider off
         div_d = '0;
         aux_out_d = 1'b0;
      end else if (aux_from_lane(aux_q.aux_out_select)) begin
         if (serializer_reinit) begin
            // lane clocking restarts, so does the divided clock
            div_d = '0;
            aux_out_d = 1'b0;
         end else if (ui_tick) begin
            if (div_q == aux_half(aux_q.aux_out_select) - 6'h01) begin
               div_d = '0;
               aux_out_d = !aux_out_q;
            end else begin
               div_d = div_q + 6'h01;
            end
         end
      end else if (aux_q.aux_out_select == SEL_TSTAMP) begin
         div_d = '0;
         aux_out_d = pins_s[PIN_TSTAMP];
      end else begin
         // reserved codes drive a quiet output
         div_d = '0;
         aux_out_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= '0;
         aux_out_q <= 1'b0;
         aux_en_q <= 1'b0;
      end else begin
         div_q <= div_d;
         aux_out_q <= aux_out_d;
         aux_en_q <= aux_q.aux_out_enable;
      end
   end

   assign aux_out_pair = aux_out_q;
   assign aux_out_enable = aux_en_q;

   // ****************************************************************
   // synthesizer control source
   // ****************************************************************
   logic synth_en_q, synth_en_d, se_q, se_d;
   logic [1:0] a_q, a_d, b_q, b_d;

   // recomputed every cycle so pin changes and mode flips reach the registered outputs on the next clock
   always_comb begin
      if (ovr_q.synth_override_enable) begin
         synth_en_d = ovr_q.synth_enable_value;
         se_d = ovr_q.se_ref_select_value;
         a_d = ovr_q.refdiv_out_a_select;
         b_d = ovr_q.refdiv_out_b_select;
      end else begin
         synth_en_d = pins_s[PIN_SYNTH_EN];
         se_d = pins_s[PIN_SE_REF];
         a_d = {pins_s[PIN_CFG1], pins_s[PIN_CFG0]};
         b_d = {pins_s[PIN_CFG1], pins_s[PIN_CFG0]};
      end
      if (a_d == REFDIV_OFF) begin
         b_d = REFDIV_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         synth_en_q <= 1'b0;
         se_q <= 1'b0;
         a_q <= REFDIV_OFF;
         b_q <= REFDIV_OFF;
      end else begin
         synth_en_q <= synth_en_d;
         se_q <= se_d;
         a_q <= a_d;
         b_q <= b_d;
      end
   end

   assign synth_enable = synth_en_q;
   assign se_ref_select = se_q;
   assign refdiv_out_a = a_q;
   assign refdiv_out_b = b_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   aux_off_a: assert property (@(posedge clk) disable iff (rst)
      !aux_q.aux_out_enable |=> !aux_out_pair && !aux_out_enable)
      else $error("aux output active while disabled");

   aux_toggle_a: assert property (@(posedge clk) disable iff (rst)
      aux_q.aux_out_enable && aux_from_lane(aux_q.aux_out_select) && ui_tick
      && !serializer_reinit && div_q == aux_half(aux_q.aux_out_select) - 6'h01
      |=> aux_out_pair != $past(aux_out_pair))
      else $error("aux clock missed its half period edge");

   tstamp_follow_a: assert property (@(posedge clk) disable iff (rst)
      aux_q.aux_out_enable && aux_q.aux_out_select == SEL_TSTAMP
      |=> aux_out_pair == $past(pins_s[PIN_TSTAMP]))
      else $error("aux output not following timestamp");

   reinit_cut_a: assert property (@(posedge clk) disable iff (rst)
      aux_q.aux_out_enable && aux_from_lane(aux_q.aux_out_select) && serializer_reinit
      |=> !aux_out_pair && div_q == 6'h00)
      else $error("aux clock kept running through reinit");

   reset_value_a: assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> aux_q == AUX_CTRL_RESET && !aux_out_pair)
      else $error("aux control not zero after reset");

   ovr_enable_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q.synth_override_enable |=> synth_enable == $past(ovr_q.synth_enable_value))
      else $error("synth enable ignores override value");

   ovr_se_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q.synth_override_enable |=> se_ref_select == $past(ovr_q.se_ref_select_value))
      else $error("reference select ignores override value");

   pin_track_a: assert property (@(posedge clk) disable iff (rst)
      !ovr_q.synth_override_enable ##1 !$past(ovr_q.synth_override_enable)
      |-> synth_enable == $past(pins_s[PIN_SYNTH_EN]))
      else $error("pin mode does not follow synth enable pin");

   pin_div_a: assert property (@(posedge clk) disable iff (rst)
      !ovr_q.synth_override_enable
      |=> refdiv_out_a == $past({pins_s[PIN_CFG1], pins_s[PIN_CFG0]}))
      else $error("pin mode divided output not from config pins");

   a_mode_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q.synth_override_enable |=> refdiv_out_a == $past(ovr_q.refdiv_out_a_select))
      else $error("first divided output ignores its field");

   b_mode_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q.synth_override_enable && ovr_q.refdiv_out_a_select != REFDIV_OFF
      |=> refdiv_out_b == $past(ovr_q.refdiv_out_b_select))
      else $error("second divided output ignores its field");

   b_needs_a_a: assert property (@(posedge clk) disable iff (rst)
      refdiv_out_a == REFDIV_OFF |-> refdiv_out_b == REFDIV_OFF)
      else $error("second output runs without the first");

endmodule

`default_nettype wire

/* File: testbench/ui_source.sv */
// serializer-side model: unit-interval tick pulses and lane reinit level
`timescale 1ns/1ps
`default_nettype none

module ui_source #(
   parameter int TICK_DIV = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control from the bench and serializer outputs
   input wire logic reinit_req,
   output logic ui_tick,
   output logic serializer_reinit
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   always_comb begin
      cnt_d = (cnt_q == 8'(TICK_DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
      if (reinit_req) begin
         cnt_d = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      cnt_q <= rst ? 8'h00 : cnt_d;
   end

   // a lane being reinitialised gives no unit intervals at all
   assign ui_tick = !rst && !reinit_req && (cnt_q == 8'(TICK_DIV - 1));
   assign serializer_reinit = reinit_req;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the aux clock output and synth pin override
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import aux_pll_pkg::*;
   localparam int TICK_DIV = 2;
   localparam int HALF_SCLK = 6;
   logic clk, rst, spi_sclk, spi_csb, spi_sdi, reinit_req, tstamp;
   logic synth_en_pin, se_pin, cfg0, cfg1;
   logic spi_sdo_out, spi_sdo_oe, ui_tick, serializer_reinit, aux_out_pair, aux_out_enable;
   logic synth_enable, se_ref_select;
   logic [1:0] refdiv_out_a, refdiv_out_b;
   logic oe_seen;
   int n_errors = 0;
   int samples_checked = 0;

   // ****************************************************************
   // clock, model and design
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ui_source #(.TICK_DIV(TICK_DIV)) u_ui (.clk(clk), .rst(rst), .reinit_req(reinit_req),
      .ui_tick(ui_tick), .serializer_reinit(serializer_reinit));

   aux_pll_ctrl u_dut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
      .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe),
      .ui_tick(ui_tick), .serializer_reinit(serializer_reinit),
      .timestamp_input_pair(tstamp), .synth_enable_pin(synth_en_pin),
      .se_ref_select_pin(se_pin), .clock_cfg_pin0(cfg0), .clock_cfg_pin1(cfg1),
      .aux_out_pair(aux_out_pair), .aux_out_enable(aux_out_enable),
      .synth_enable(synth_enable), .se_ref_select(se_ref_select),
      .refdiv_out_a(refdiv_out_a), .refdiv_out_b(refdiv_out_b));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // mode 0 frame; sdo is sampled a full half period after the fall, past the sync lag
   task automatic spi_xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                           output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      oe_seen = 1'b0;
      spi_csb = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = frame[i];
         wait_clk(HALF_SCLK);
         if (i < 8) begin
            rdata[i] = spi_sdo_out;
            oe_seen = spi_sdo_oe;
         end
         spi_sclk = 1'b1;
         wait_clk(HALF_SCLK);
         spi_sclk = 1'b0;
      end
      wait_clk(HALF_SCLK);
      spi_csb = 1'b1;
      wait_clk(8);
   endtask

   task automatic reg_wr(input logic [14:0] addr, input logic [7:0] data);
      logic [7:0] unused;
      spi_xfer(1'b0, addr, data, unused);
      check_val("sdo_oe_write", 8'h00, {7'h00, oe_seen});
   endtask

   task automatic reg_chk(input string what, input logic [14:0] addr, input logic [7:0] exp);
      logic [7:0] got;
      spi_xfer(1'b1, addr, 8'h00, got);
      check_val(what, exp, got);
      check_val("sdo_oe_read", 8'h01, {7'h00, oe_seen});
      check_val("sdo_oe_idle", 8'h00, {7'h00, spi_sdo_oe});
   endtask

   task automatic check_synth(input logic en, input logic se, input logic [1:0] a,
                              input logic [1:0] b);
      check_val("synth_ctrl", {2'h0, en, se, a, b},
                {2'h0, synth_enable, se_ref_select, refdiv_out_a, refdiv_out_b});
   endtask

   // aligns on one aux edge, then counts cycles to the next
   task automatic measure_half(output int n);
      logic lvl;
      for (int k = 0; k < 2; k++) begin
         lvl = aux_out_pair;
         n = 0;
         while (aux_out_pair === lvl && n < 300) begin
            wait_clk(1);
            n++;
         end
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      check_val("aux_enable", 8'h00, {7'h00, aux_out_enable});
      check_val("aux_out", 8'h00, {7'h00, aux_out_pair});
      reg_chk("aux_ctrl", ADDR_AUX_CTRL, 8'h00);
      reg_chk("synth_ovr", ADDR_SYNTH_OVR, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_regs();
      reg_wr(ADDR_AUX_CTRL, 8'h02);
      check_val("aux_enable", 8'h00, {7'h00, aux_out_enable});
      reg_wr(ADDR_AUX_CTRL, 8'h82);
      check_val("aux_enable", 8'h01, {7'h00, aux_out_enable});
      reg_wr(15'h0056, 8'hff);
      reg_chk("unmapped", 15'h0056, 8'h00);
      reg_chk("aux_ctrl", ADDR_AUX_CTRL, 8'h82);
      reg_wr(ADDR_AUX_CTRL, 8'h02);
      check_val("aux_enable", 8'h00, {7'h00, aux_out_enable});
      $display("test registers done");
   endtask

   task automatic t_lane();
      int ui[3] = '{16, 32, 64};
      int n;
      for (int c = 0; c < 3; c++) begin
         reg_wr(ADDR_AUX_CTRL, 8'(c));
         reg_wr(ADDR_AUX_CTRL, 8'h80 | 8'(c));
         measure_half(n);
         check_val("aux_half", 8'(ui[c] / 2 * TICK_DIV), 8'(n));
         reinit_req = 1'b1;
         wait_clk(3);
         check_val("aux_reinit", 8'h00, {7'h00, aux_out_pair});
         reinit_req = 1'b0;
         wait_clk(2);
         reg_wr(ADDR_AUX_CTRL, 8'(c));
      end
      $display("test lane clocks done");
   endtask

   task automatic t_tstamp();
      reg_wr(ADDR_AUX_CTRL, 8'h03);
      reg_wr(ADDR_AUX_CTRL, 8'h83);
      tstamp = 1'b1;
      wait_clk(8);
      check_val("aux_tstamp", 8'h01, {7'h00, aux_out_pair});
      tstamp = 1'b0;
      wait_clk(8);
      check_val("aux_tstamp", 8'h00, {7'h00, aux_out_pair});
      reg_wr(ADDR_AUX_CTRL, 8'h03);
      tstamp = 1'b1;
      wait_clk(8);
      check_val("aux_disabled", 8'h00, {7'h00, aux_out_pair});
      reg_wr(ADDR_AUX_CTRL, 8'h04);
      reg_wr(ADDR_AUX_CTRL, 8'h84);
      wait_clk(8);
      check_val("aux_reserved", 8'h00, {7'h00, aux_out_pair});
      reg_wr(ADDR_AUX_CTRL, 8'h04);
      reg_wr(ADDR_AUX_CTRL, 8'h00);
      tstamp = 1'b0;
      $display("test timestamp done");
   endtask

   task automatic t_pins();
      logic [3:0] p;
      for (int j = 0; j < 16; j++) begin
         p = 4'(j);
         {cfg1, cfg0, se_pin, synth_en_pin} = p;
         wait_clk(8);
         check_synth(p[0], p[1], p[3:2], p[3:2]);
      end
      $display("test pin mode done");
   endtask

   task automatic t_override();
      logic [3:0] p;
      logic [1:0] b_exp;
      {cfg1, cfg0, se_pin, synth_en_pin} = 4'hf;
      for (int j = 0; j < 16; j++) begin
         p = 4'(j);
         b_exp = (p[1:0] == REFDIV_OFF) ? REFDIV_OFF : p[3:2];
         reg_wr(ADDR_SYNTH_OVR, {2'b10, p[3:2], p[1:0], ~p[0], ~p[1]});
         check_synth(~p[1], ~p[0], p[1:0], b_exp);
      end
      reg_chk("synth_ovr", ADDR_SYNTH_OVR, 8'hbc);
      reg_wr(ADDR_SYNTH_OVR, 8'h00);
      check_synth(1'b1, 1'b1, 2'h3, 2'h3);
      {cfg1, cfg0, se_pin, synth_en_pin} = 4'h0;
      wait_clk(8);
      check_synth(1'b0, 1'b0, 2'h0, 2'h0);
      $display("test override done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      rst = 1'b1;
      spi_sclk = 1'b0;
      spi_csb = 1'b1;
      spi_sdi = 1'b0;
      reinit_req = 1'b0;
      tstamp = 1'b0;
      synth_en_pin = 1'b0;
      se_pin = 1'b0;
      cfg0 = 1'b0;
      cfg1 = 1'b0;
      wait_clk(6);
      rst = 1'b0;
      wait_clk(6);
      t_reset();
      t_regs();
      t_lane();
      t_tstamp();
      t_pins();
      t_override();
      test_done();
   end

   // about 40 frames of 300 cycles are expected; this leaves ample margin
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      test_done();
   end
endmodule
`default_nettype wire
